/* logic/ehs_ack_det.sv */
// module: trigger-in synchroniser and edge-selectable acknowledge detector
module ehs_ack_det
  import ehs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trig_in,
  ehs_ack_if.det ack_bus
);

  // ==========================================================
  // synchroniser and edge history
  logic sync1_ff; // first stage, read only by sync2_ff
  logic sync2_ff; // stable level
  logic hist_ff; // previous stable level

  // two-stage synchroniser plus one history stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      hist_ff <= 1'b1;
    end else begin
      sync1_ff <= trig_in;
      sync2_ff <= sync1_ff;
      hist_ff <= sync2_ff;
    end
  end

  // ==========================================================
  // edge select and arming
  logic rise; // stable level went high
  logic fall; // stable level went low
  assign rise = sync2_ff & ~hist_ff;
  assign fall = ~sync2_ff & hist_ff;
  // edges outside the wait window are dropped
  assign ack_bus.ack = ack_bus.armed & (ack_bus.edge_rising ? rise : fall);

  // ==========================================================
  // checks
  a_ack_armed: assert property (@(posedge pclk) disable iff (!presetn)
    ack_bus.ack |-> ack_bus.armed && ($past(trig_in, 2) == ack_bus.edge_rising) &&
      ($past(trig_in, 3) != ack_bus.edge_rising))
    else $error("ack seen while not armed or not after two sync stages");
  a_ack_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    ack_bus.ack |-> (sync2_ff == ack_bus.edge_rising) && ($past(sync2_ff) != sync2_ff))
    else $error("ack on wrong edge");

endmodule

/* logic/ehs_ack_if.sv */
// interface: acknowledge detector handshake between sequencer and input stage
interface ehs_ack_if;
  logic edge_rising; // edge polarity select
  logic armed; // detector listens only when high
  logic ack; // one-cycle acknowledge pulse

  modport det (input edge_rising, input armed, output ack);
  modport seq (output edge_rising, output armed, input ack);
endinterface

/* logic/ehs_pkg.sv */
// package: register map, field positions, reset values and states of the trigger handshake
// Notes on behaviour
// - handshake on: repeat programmed cycle count before scanner advances
// - trigger-out pulse length comes from setting
// - handshake on: wait for ack or timeout
// - handshake off: one pulse per point, no wait
// - timeout: next pulse if cycles remain, else advance
// - zero timeout means wait for ack forever
// - ack edge polarity chosen by one bit
// - first test command fires one pulse, waits only if handshake on
// - handshake on: second test command acts as the ack
// - command after timeout starts a fresh cycle
// - waiting flag high exactly while awaiting ack
// - outside test mode, pulse only after tip reached target point
package ehs_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] EHS_OFS_CTRL = 8'h00; // enables and edge select
  localparam logic [7:0] EHS_OFS_COUNT = 8'h04; // cycles per point
  localparam logic [7:0] EHS_OFS_PULSE = 8'h08; // pulse length in clocks
  localparam logic [7:0] EHS_OFS_TIMEOUT = 8'h0c; // ack timeout in clocks
  localparam logic [7:0] EHS_OFS_CMD = 8'h10; // write-only test command
  localparam logic [7:0] EHS_OFS_STATUS = 8'h14; // waiting and busy flags
  localparam logic [7:0] EHS_OFS_CYCLES = 8'h18; // cycles left at this point

  // ==========================================================
  // field positions
  localparam int EHS_CTRL_HS_EN = 0; // wait for ack after each pulse
  localparam int EHS_CTRL_RISING = 1; // 1 rising, 0 falling ack edge
  localparam int EHS_CTRL_TEST = 2; // manual test mode
  localparam int EHS_CMD_GO = 0; // test command bit
  localparam int EHS_ST_WAIT = 0; // waiting for ack
  localparam int EHS_ST_BUSY = 1; // sequence active

  // ==========================================================
  // values after reset
  localparam logic [2:0] EHS_CTRL_RST = 3'h0; // handshake off, falling edge
  localparam logic [31:0] EHS_COUNT_RST = 32'h0000_0001; // one cycle
  localparam logic [31:0] EHS_PULSE_RST = 32'h0000_9c40; // 40000 clocks, 1 ms at 40 MHz
  localparam logic [31:0] EHS_TIMEOUT_RST = 32'h0000_0000; // timeout off

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    EHS_IDLE = 2'b00, // waiting for a point
    EHS_PULSE = 2'b01, // trigger-out high
    EHS_WAIT = 2'b10 // waiting for acknowledge
  } ehs_state_t;

endpackage

/* logic/ehs_top.sv */
// module: per-point trigger handshake sequencer with apb register slave
module ehs_top
  import ehs_pkg::*;
#(
  parameter int CNT_W = 16, // cycle counter width
  parameter int PULSE_W = 24, // pulse length width
  parameter int TO_W = 32 // timeout width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic point_reached, // tip at target, one-cycle pulse
  input wire logic trig_in, // acknowledge line from the instrument
  output logic trig_out, // trigger pulse to the instrument
  output logic advance, // one-cycle pulse: scanner may move on
  output logic waiting_ack // high while awaiting acknowledge
);

  // ==========================================================
  // apb decode
  logic setup_ph; // first cycle of a transfer
  logic access_ph; // completing cycle of a transfer
  logic addr_hit; // address is mapped
  logic wr_en; // write takes effect this edge
  logic test_cmd; // test command written this edge

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready = 1'b1; // no wait states
  assign wr_en = access_ph & pwrite;

  // mapped address check
  always_comb begin
    if (paddr == EHS_OFS_CTRL) begin
      addr_hit = 1'b1;
    end else if (paddr == EHS_OFS_COUNT || paddr == EHS_OFS_PULSE) begin
      addr_hit = 1'b1;
    end else if (paddr == EHS_OFS_TIMEOUT || paddr == EHS_OFS_CMD) begin
      addr_hit = 1'b1;
    end else if (paddr == EHS_OFS_STATUS || paddr == EHS_OFS_CYCLES) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  assign pslverr = access_ph & ~addr_hit; // unmapped access flagged

  // ==========================================================
  // configuration registers
  logic [2:0] ctrl_ff; // enables and edge select
  logic [CNT_W-1:0] count_ff; // cycles per point
  logic [PULSE_W-1:0] pulse_ff; // pulse length in clocks
  logic [TO_W-1:0] timeout_ff; // timeout in clocks, zero is off

  // software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= EHS_CTRL_RST;
      count_ff <= EHS_COUNT_RST[CNT_W-1:0];
      pulse_ff <= EHS_PULSE_RST[PULSE_W-1:0];
      timeout_ff <= EHS_TIMEOUT_RST[TO_W-1:0];
    end else if (wr_en) begin
      if (paddr == EHS_OFS_CTRL) begin
        ctrl_ff <= pwdata[2:0];
      end else if (paddr == EHS_OFS_COUNT) begin
        count_ff <= pwdata[CNT_W-1:0];
      end else if (paddr == EHS_OFS_PULSE) begin
        pulse_ff <= pwdata[PULSE_W-1:0];
      end else if (paddr == EHS_OFS_TIMEOUT) begin
        timeout_ff <= pwdata[TO_W-1:0];
      end
    end
  end

  logic hs_en; // wait for ack after each pulse
  logic test_mode; // manual test command drives the sequence
  assign hs_en = ctrl_ff[EHS_CTRL_HS_EN];
  assign test_mode = ctrl_ff[EHS_CTRL_TEST];
  assign test_cmd = wr_en & (paddr == EHS_OFS_CMD) & pwdata[EHS_CMD_GO];

  // ==========================================================
  // acknowledge detector
  ehs_state_t state_ff; // sequencer state
  ehs_ack_if ack_bus(); // detector link

  assign ack_bus.edge_rising = ctrl_ff[EHS_CTRL_RISING];
  assign ack_bus.armed = (state_ff == EHS_WAIT);

  ehs_ack_det u_ack_det (
    .pclk(pclk),
    .presetn(presetn),
    .trig_in(trig_in),
    .ack_bus(ack_bus.det)
  );

  // ==========================================================
  // sequencer
  logic [TO_W-1:0] tmr_ff; // pulse and wait timer
  logic [CNT_W-1:0] cyc_ff; // cycles left at this point
  logic trig_ff; // trigger-out register
  logic adv_ff; // advance pulse register
  logic wait_ff; // waiting flag register
  ehs_state_t nxt_state;
  logic [TO_W-1:0] nxt_tmr;
  logic [CNT_W-1:0] nxt_cyc;
  logic nxt_adv;
  logic [TO_W-1:0] eff_pulse; // pulse length, at least one clock
  logic [CNT_W-1:0] eff_cnt; // cycle count, at least one
  logic start_req; // begin a new point
  logic ack_any; // acknowledge from pin or test command
  logic timed_out; // wait reached the timeout
  logic cyc_done; // one handshake cycle finished

  assign eff_pulse = (pulse_ff == '0) ? TO_W'(1) : TO_W'(pulse_ff);
  assign eff_cnt = (count_ff == '0) ? CNT_W'(1) : count_ff;
  // point arrival starts normal runs, test command starts manual ones
  assign start_req = test_mode ? test_cmd : point_reached;
  assign ack_any = ack_bus.ack | (test_mode & test_cmd);
  assign timed_out = (timeout_ff != '0) && (tmr_ff >= timeout_ff - 1'b1);

  // next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff + 1'b1;
    nxt_cyc = cyc_ff;
    nxt_adv = 1'b0;
    cyc_done = 1'b0;
    case (state_ff)
      EHS_IDLE: begin
        nxt_tmr = '0;
        // a command after a timed-out run lands here and restarts
        if (start_req) begin
          nxt_state = EHS_PULSE;
          nxt_cyc = eff_cnt;
        end
      end
      EHS_PULSE: begin
        if (tmr_ff >= eff_pulse - 1'b1) begin
          nxt_tmr = '0;
          if (hs_en) begin
            nxt_state = EHS_WAIT;
          end else begin
            nxt_state = EHS_IDLE;
            nxt_adv = 1'b1;
          end
        end
      end
      EHS_WAIT: begin
        cyc_done = ack_any | timed_out;
      end
      default: begin
        nxt_state = EHS_IDLE;
      end
    endcase
    // end of a cycle: repeat or release the scanner
    if (cyc_done) begin
      nxt_tmr = '0;
      if (cyc_ff > CNT_W'(1)) begin
        nxt_state = EHS_PULSE;
        nxt_cyc = cyc_ff - 1'b1;
      end else begin
        nxt_state = EHS_IDLE;
        nxt_adv = 1'b1;
      end
    end
  end

  // state and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= EHS_IDLE;
      tmr_ff <= '0;
      cyc_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      cyc_ff <= nxt_cyc;
    end
  end

  // registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ff <= 1'b0;
      adv_ff <= 1'b0;
      wait_ff <= 1'b0;
    end else begin
      trig_ff <= (nxt_state == EHS_PULSE);
      adv_ff <= nxt_adv;
      wait_ff <= (nxt_state == EHS_WAIT);
    end
  end

  assign trig_out = trig_ff;
  assign advance = adv_ff;
  assign waiting_ack = wait_ff;

  // ==========================================================
  // read data, captured in the setup phase
  logic [31:0] rdata_ff;

  // read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else if (setup_ph && !pwrite) begin
      if (paddr == EHS_OFS_CTRL) begin
        rdata_ff <= {29'h0, ctrl_ff};
      end else if (paddr == EHS_OFS_COUNT) begin
        rdata_ff <= 32'(count_ff);
      end else if (paddr == EHS_OFS_PULSE) begin
        rdata_ff <= 32'(pulse_ff);
      end else if (paddr == EHS_OFS_TIMEOUT) begin
        rdata_ff <= 32'(timeout_ff);
      end else if (paddr == EHS_OFS_STATUS) begin
        rdata_ff <= {30'h0, (state_ff != EHS_IDLE), wait_ff};
      end else if (paddr == EHS_OFS_CYCLES) begin
        rdata_ff <= 32'(cyc_ff);
      end else begin
        rdata_ff <= '0; // unmapped and command read as zero
      end
    end
  end

  assign prdata = rdata_ff;

  // ==========================================================
  // checks
  logic [TO_W-1:0] hi_len_ff; // helper: length of current trigger pulse

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_len_ff <= '0;
    end else if (trig_ff) begin
      hi_len_ff <= hi_len_ff + 1'b1;
    end else begin
      hi_len_ff <= '0;
    end
  end

  a_pulse_length: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(trig_ff) |-> $past(hi_len_ff) + 1'b1 == $past(eff_pulse))
    else $error("trigger pulse length differs from setting");
  a_wait_exact: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(waiting_ack) |-> $fell(trig_out) && $past(hs_en)) and
    ($fell(waiting_ack) |-> $past(ack_any) || $past(timed_out)))
    else $error("waiting flag out of step with wait state");
  a_point_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == EHS_IDLE && !test_mode && point_reached) |=> trig_out && !waiting_ack)
    else $error("no trigger after point reached");
  a_no_hs_adv: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(trig_out) && !$past(hs_en)) |-> advance && state_ff == EHS_IDLE)
    else $error("no advance after pulse without handshake");
  a_timeout_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == EHS_WAIT && timed_out && cyc_ff > CNT_W'(1)) |=> trig_out && !advance)
    else $error("timeout did not restart the pulse");
  a_zero_to_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == EHS_WAIT && timeout_ff == '0 && !ack_any) |=> waiting_ack)
    else $error("left wait without ack while timeout off");
  a_last_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == EHS_WAIT && cyc_done && cyc_ff <= CNT_W'(1)) |=> advance ##1 !advance)
    else $error("last cycle did not release scanner");
  a_test_fire: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == EHS_IDLE && test_mode && test_cmd) |=> trig_out [*1] ##0 !advance)
    else $error("test command did not fire");
  a_test_ack: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == EHS_WAIT && test_mode && test_cmd) |=> !waiting_ack && (advance || trig_out))
    else $error("test command not taken as ack");

endmodule

/* testbench/ehs_instr.sv */
// model: external instrument answering each trigger with an acknowledge pulse
module ehs_instr (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trig_out,
  input wire logic respond, // answer at all when high
  input wire logic rising, // pulse polarity to match edge select
  input wire logic [7:0] delay, // clocks from trigger end to answer
  output logic trig_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // answer logic
  logic out_q; // last trigger level
  int cnt; // delay countdown
  int hold; // answer pulse width countdown
  // measure done some clocks after trigger falls, then answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
      cnt <= 0;
      hold <= 0;
      trig_in <= 1'b1;
    end else begin
      out_q <= trig_out;
      if (out_q && !trig_out && respond) begin
        cnt <= delay + 1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      if (cnt == 1) begin
        trig_in <= rising; // active level
        hold <= 4;
      end else if (hold > 0) begin
        hold <= hold - 1;
      end else begin
        trig_in <= ~rising; // idle level
      end
    end
  end
endmodule

/* testbench/external_trigger_handshake_bench.sv */
// testbench: random and corner handshake runs against the instrument model
module external_trigger_handshake_bench import ehs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, point_reached, respond, rising;
  logic [7:0] paddr, delay, seed;
  logic [31:0] pwdata, prdata, rq;
  logic pready, pslverr, trig_in, trig_out, advance, waiting_ack, re;
  int err_total, n_tests, n_pulse, n_adv, n_wait, hi_len, wt_len, exp_pulse, exp_wait, cyc;
  ehs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .point_reached(point_reached), .trig_in(trig_in),
    .trig_out(trig_out), .advance(advance), .waiting_ack(waiting_ack));
  ehs_instr inst (.pclk(pclk), .presetn(presetn), .trig_out(trig_out), .respond(respond),
    .rising(rising), .delay(delay), .trig_in(trig_in));
  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rq);
  endtask
  task automatic clr();
    n_pulse = 0;
    n_adv = 0;
    n_wait = 0;
  endtask
  task automatic point();
    clr();
    @(posedge pclk);
    point_reached <= 1'b1;
    @(posedge pclk);
    point_reached <= 1'b0;
  endtask
  // bounded wait for advances, then compare totals
  task automatic settle(input int advs, input int pulses);
    int k;
    k = 0;
    while (n_adv < advs && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    repeat (4) @(posedge pclk);
    chk("advance count", advs, n_adv);
    chk("pulse count", pulses, n_pulse);
  endtask
  // ==========================================================
  // clock, watchdog and output monitor
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  always @(posedge pclk) begin
    if (trig_out === 1'b1) hi_len++;
    else if (hi_len != 0) begin
      chk("pulse length", exp_pulse, hi_len);
      hi_len = 0;
      n_pulse++;
    end
    if (waiting_ack === 1'b1) wt_len++;
    else if (wt_len != 0) begin
      if (exp_wait != 0) chk("wait length", exp_wait, wt_len);
      wt_len = 0;
      n_wait++;
    end
    if (advance === 1'b1) n_adv++;
    if (trig_out === 1'b1 && waiting_ack === 1'b1) chk("wait in pulse", 0, 1);
  end
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, point_reached, rising} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    respond = 1'b1;
    delay = 8'h2;
    seed = 8'h45;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(EHS_OFS_CTRL, {29'h0, EHS_CTRL_RST}, "ctrl");
    rd(EHS_OFS_COUNT, EHS_COUNT_RST, "count");
    rd(EHS_OFS_PULSE, EHS_PULSE_RST, "pulse");
    rd(EHS_OFS_TIMEOUT, EHS_TIMEOUT_RST, "timeout");
    rd(EHS_OFS_CMD, 32'h0, "cmd");
    rd(8'h40, 32'h0, "unmapped data");
    chk("unmapped error", 1, re);
    // handshake off: one pulse, count ignored
    exp_pulse = 3;
    wr(EHS_OFS_PULSE, 32'h3);
    wr(EHS_OFS_COUNT, 32'h3);
    point();
    settle(1, 1);
    chk("no wait", 0, n_wait);
    // random runs over both edges and counts
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      exp_pulse = seed % 6 + 1;
      rising <= i[0];
      delay <= {5'h0, seed[7:5]};
      wr(EHS_OFS_PULSE, exp_pulse);
      wr(EHS_OFS_CTRL, {30'h0, i[0], 1'b1});
      wr(EHS_OFS_COUNT, i % 3 + 1);
      point();
      settle(1, i % 3 + 1);
    end
    // silent instrument: timeout repeats then advances
    respond <= 1'b0;
    exp_wait = 10;
    wr(EHS_OFS_TIMEOUT, 32'ha);
    wr(EHS_OFS_COUNT, 32'h2);
    point();
    settle(1, 2);
    // zero count and zero length both behave as one
    exp_pulse = 1;
    wr(EHS_OFS_PULSE, 32'h0);
    wr(EHS_OFS_COUNT, 32'h0);
    point();
    settle(1, 1);
    // zero timeout: holds until late answer
    respond <= 1'b1;
    delay <= 8'hff;
    exp_wait = 0;
    wr(EHS_OFS_TIMEOUT, 32'h0);
    wr(EHS_OFS_COUNT, 32'h1);
    point();
    repeat (200) @(posedge pclk);
    chk("still waiting", 1, waiting_ack);
    chk("no early advance", 0, n_adv);
    settle(1, 1);
    // test mode: command fires, second command acknowledges
    respond <= 1'b0;
    rising <= 1'b0;
    wr(EHS_OFS_CTRL, 32'h5);
    clr();
    wr(EHS_OFS_CMD, 32'h1);
    repeat (exp_pulse + 2) @(posedge pclk);
    rd(EHS_OFS_STATUS, 32'h3, "status waiting");
    rd(EHS_OFS_CYCLES, 32'h1, "cycles left");
    wr(EHS_OFS_CMD, 32'h1);
    settle(1, 1);
    // timeout first: later command starts a fresh cycle
    exp_wait = 6;
    wr(EHS_OFS_TIMEOUT, 32'h6);
    clr();
    wr(EHS_OFS_CMD, 32'h1);
    settle(1, 1);
    wr(EHS_OFS_CMD, 32'h1);
    settle(2, 2);
    summarize();
  end
endmodule
